// ==== hdl/ser_ctrl_pkg.sv ====
// Shared constants and types of the serializer control block.
package ser_ctrl_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_CH = 8;
  localparam int WORD_BITS = 10;
  localparam int FRAME_BITS = 12;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [2:0] WORD_DIV_LAST = 3'h3;
  localparam logic [2:0] ALIGN_FRAMES = 3'h4;
  localparam int RECOVERY_NS = 100;
  localparam int RECOVERY_CYC_I =
    (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] RECOVERY_CYC = RECOVERY_CYC_I[5:0];
  localparam int RUNBIST_MS = 33;
  localparam int TX_CLK_MAX_MHZ = 66;
  localparam int RUNBIST_FRAMES_DEF = RUNBIST_MS * TX_CLK_MAX_MHZ * 1000;

  // ==========================================================
  // Patterns
  localparam logic [11:0] SYNC_FRAME = 12'hfc0;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  localparam logic [3:0] SEL_ALL = 4'h8;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRAMES = 8'h08;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam int CTL_SW_ACT = 0;
  localparam int CTL_SEL_LSB = 4;
  localparam int ST_ACTIVE_LSB = 0;
  localparam int ST_BIST_LSB = 8;
  localparam int ST_PLL = 16;
  localparam int ST_RB_BUSY = 17;
  localparam int ST_RB_DONE = 18;
  localparam int ST_RX_PASS = 19;
  localparam int ST_RX_DONE = 20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // States
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_WAKE = 2'b01,
    CH_DATA = 2'b10,
    CH_SYNC = 2'b11
  } ch_mode_e;

  typedef enum logic [1:0] {
    RB_IDLE = 2'b00,
    RB_RUN = 2'b01,
    RB_DONE = 2'b10
  } rb_state_e;

endpackage

// ==== hdl/ser_channel.sv ====
// One serializer channel: power, align, self-test and output enable.
`timescale 1ns/1ps
module ser_channel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controls
  input wire logic frame_tick,
  input wire logic pll_run,
  input wire logic chan_awake,
  input wire logic align_req,
  input wire logic drive_en,
  input wire logic bist_en,
  input wire logic bist_restart,
  input wire logic extest_en,
  input wire logic extest_bit,
  input wire logic [9:0] parallel_data,
  // Outputs
  output logic [11:0] frame_out,
  output logic oe,
  output logic active
);
  import ser_ctrl_pkg::*;

  typedef struct packed {
    ch_mode_e mode;
    logic [5:0] rec_cnt;
    logic [2:0] align_cnt;
    logic [6:0] prbs;
    logic [11:0] frame;
    logic oe;
  } ch_s;

  ch_s st_r;
  ch_s st_nxt;

  function automatic logic [16:0] prbs_step(input logic [6:0] s);
    logic [6:0] v;
    logic [9:0] w;
    v = s;
    w = 10'h000;
    for (int i = 0; i < 10; i++) begin
      w = {w[8:0], v[6]};
      v = {v[5:0], v[6] ^ v[5]};
    end
    return {w, v};
  endfunction

  logic [16:0] step;

  always_comb begin
    st_nxt = st_r;
    step = prbs_step(st_r.prbs);
    if (!pll_run || !chan_awake) begin
      st_nxt.mode = CH_OFF;
      st_nxt.align_cnt = 3'h0;
    end else begin
      case (st_r.mode)
        CH_OFF: begin
          st_nxt.mode = CH_WAKE;
          st_nxt.rec_cnt = RECOVERY_CYC - 6'h01;
        end
        CH_WAKE: begin
          if (st_r.rec_cnt == 6'h00) begin
            st_nxt.mode = CH_DATA;
          end else begin
            st_nxt.rec_cnt = st_r.rec_cnt - 6'h01;
          end
        end
        CH_DATA, CH_SYNC: begin
          if (frame_tick) begin
            if (!align_req) begin
              st_nxt.align_cnt = 3'h0;
              st_nxt.mode = CH_DATA;
            end else if (st_r.align_cnt + 3'h1 >= ALIGN_FRAMES) begin
              st_nxt.align_cnt = ALIGN_FRAMES;
              st_nxt.mode = CH_SYNC;
            end else begin
              st_nxt.align_cnt = st_r.align_cnt + 3'h1;
            end
          end
        end
        default: st_nxt.mode = CH_OFF;
      endcase
    end
    if (bist_restart) begin
      st_nxt.prbs = PRBS_SEED;
    end else if (frame_tick && bist_en) begin
      st_nxt.prbs = step[6:0];
    end
    if (frame_tick) begin
      if (extest_en) begin
        st_nxt.frame = {12{extest_bit}};
      end else if (st_r.mode == CH_SYNC) begin
        st_nxt.frame = SYNC_FRAME;
      end else if (bist_en) begin
        st_nxt.frame = {1'b1, step[16:7], 1'b0};
      end else begin
        st_nxt.frame = {1'b1, parallel_data, 1'b0};
      end
    end
    st_nxt.oe = drive_en && pll_run && chan_awake && (extest_en ||
      st_nxt.mode == CH_DATA || st_nxt.mode == CH_SYNC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{mode: CH_OFF, rec_cnt: 6'h00, align_cnt: 3'h0,
        prbs: PRBS_SEED, frame: 12'h000, oe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign frame_out = st_r.frame;
  assign oe = st_r.oe;
  assign active = st_r.oe && st_r.mode == CH_DATA && !extest_en;

  // ==========================================================
  // Checks
  property p_align_sync;
    @(posedge aclk) disable iff (!aresetn)
    frame_tick && align_req && pll_run && chan_awake &&
      st_r.mode == CH_DATA && st_r.align_cnt == 3'h3 |=>
      st_r.mode == CH_SYNC;
  endproperty
  a_align_sync: assert property (p_align_sync)
    else $error("Align request did not switch channel to sync.");

  property p_chan_sleep;
    @(posedge aclk) disable iff (!aresetn)
    !chan_awake |=> !oe && st_r.mode == CH_OFF;
  endproperty
  a_chan_sleep: assert property (p_chan_sleep)
    else $error("Sleeping channel still drives its output.");

  property p_recovery;
    @(posedge aclk) disable iff (!aresetn)
    st_r.mode == CH_WAKE && st_r.rec_cnt == 6'h00 && pll_run &&
      chan_awake |=> st_r.mode == CH_DATA;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("Channel did not resume after recovery delay.");

  property p_sync_frame;
    @(posedge aclk) disable iff (!aresetn)
    frame_tick && st_r.mode == CH_SYNC && !extest_en |=>
      frame_out == SYNC_FRAME;
  endproperty
  a_sync_frame: assert property (p_sync_frame)
    else $error("Sync frame content wrong.");

  property p_prbs_restart;
    @(posedge aclk) disable iff (!aresetn)
    bist_restart |=> st_r.prbs == PRBS_SEED;
  endproperty
  a_prbs_restart: assert property (p_prbs_restart)
    else $error("Pattern generator did not restart at seed.");

endmodule

// ==== hdl/serializer_power_tristate_bist_ctrl.sv ====
// Control logic of an eight-channel serializer with self-test.
//
// What this block does
// - Once a channel's align request has been high four frames, it sends sync patterns.
// - Master sleep low stops the PLL and floats every output.
// - Channel sleep floats only that channel; PLL and others keep running.
// - Waking channel resumes after a short fixed delay; no new init.
// - Output drive enable low floats all eight outputs, whatever else.
// - Drive enable back high resumes the prior state unchanged.
// - Each channel can send internal pseudo-random bits instead of data.
// - Activate high with select 0 to 7 tests that one channel.
// - Activate high with select 8 tests all channels together.
// - Select 9 to 15 runs no self-test on any channel.
// - Boundary scan drives static output levels for connectivity checks.
// - Scan-started self-test runs about 33 ms of 66 MHz frames.
// - Receiver reports pass/fail and complete; pass means BER below 1e-7.
// - Pattern starts when the scan port idles with self-test loaded.
// - Output drives only with enable and both sleeps high; align high still drives.
// - Align request held four frames replaces data with sync pulses.
// - Sync pattern is six ones then six zeros at frame rate.
`timescale 1ns/1ps
module serializer_power_tristate_bist_ctrl #(
  parameter int RUNBIST_FRAMES = ser_ctrl_pkg::RUNBIST_FRAMES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power and output control pins
  input wire logic master_sleep_n,
  input wire logic [7:0] channel_sleep_n,
  input wire logic output_drive_enable,
  input wire logic [7:0] link_align_request,
  input wire logic [79:0] parallel_data_in,
  // Self-test pins
  input wire logic selftest_activate,
  input wire logic [3:0] selftest_channel_select,
  // Boundary-scan controls
  input wire logic runbist_loaded,
  input wire logic tap_run_test_idle,
  input wire logic extest_active,
  input wire logic [7:0] extest_data,
  // Remote receiver self-test status
  input wire logic remote_bist_pass,
  input wire logic remote_bist_done,
  // Serial side
  output logic [95:0] serial_frame,
  output logic [7:0] serial_out_oe,
  output logic pll_run
);
  import ser_ctrl_pkg::*;

  localparam int SYNC_W = 116;
  localparam logic [21:0] RB_LAST = 22'(RUNBIST_FRAMES - 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [SYNC_W-1:0] pin_s1;
    logic [SYNC_W-1:0] pin_s2;
    logic [2:0] div_cnt;
    logic tick;
    rb_state_e rb_state;
    logic [21:0] rb_cnt;
    logic bist_any;
    logic [31:0] control;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  // ==========================================================
  // Synchronised pins
  logic ms_n;
  logic drv_en;
  logic pin_act;
  logic [3:0] pin_sel;
  logic [7:0] ch_sleep_n;
  logic [7:0] align_req;
  logic rb_loaded;
  logic tap_rti;
  logic ext_en;
  logic [7:0] ext_bit;
  logic rx_pass;
  logic rx_done;
  logic [79:0] pdata;

  assign {ms_n, drv_en, pin_act, pin_sel, ch_sleep_n, align_req, rb_loaded,
    tap_rti, ext_en, ext_bit, rx_pass, rx_done, pdata} = st_r.pin_s2;

  // ==========================================================
  // Self-test selection
  logic act;
  logic [3:0] sel;
  logic rb_run;
  logic [7:0] bist_vec;
  logic bist_restart;
  logic [7:0] ch_active;

  always_comb begin
    act = pin_act || st_r.control[CTL_SW_ACT];
    sel = st_r.control[CTL_SW_ACT] ?
      st_r.control[CTL_SEL_LSB +: 4] : pin_sel;
    rb_run = st_r.rb_state == RB_RUN;
    bist_vec = 8'h00;
    if (rb_run) begin
      bist_vec = 8'hff;
    end else if (act && sel == SEL_ALL) begin
      bist_vec = 8'hff;
    end else if (act && !sel[3]) begin
      bist_vec[sel[2:0]] = 1'b1;
    end
  end

  assign bist_restart = (|bist_vec) && !st_r.bist_any;

  // ==========================================================
  // Channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ser_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .frame_tick(st_r.tick),
      .pll_run(ms_n),
      .chan_awake(ch_sleep_n[c]),
      .align_req(align_req[c]),
      .drive_en(drv_en),
      .bist_en(bist_vec[c]),
      .bist_restart(bist_restart),
      .extest_en(ext_en),
      .extest_bit(ext_bit[c]),
      .parallel_data(pdata[c*WORD_BITS +: WORD_BITS]),
      .frame_out(serial_frame[c*FRAME_BITS +: FRAME_BITS]),
      .oe(serial_out_oe[c]),
      .active(ch_active[c])
    );
  end

  // PLL runs only while the master sleep pin is high.
  assign pll_run = ms_n;

  // ==========================================================
  // Next state
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [31:0] wmask;
  logic [31:0] status;

  assign awready = !st_r.aw_held && !st_r.bvalid;
  assign wready = !st_r.w_held && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign ar_hs = arvalid && arready;

  always_comb begin
    st_nxt = st_r;
    wmask = 32'h0000_0000;
    status = 32'h0000_0000;
    st_nxt.pin_s1 = {master_sleep_n, output_drive_enable, selftest_activate,
      selftest_channel_select, channel_sleep_n, link_align_request,
      runbist_loaded, tap_run_test_idle, extest_active, extest_data,
      remote_bist_pass, remote_bist_done, parallel_data_in};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.bist_any = |bist_vec;
    // Frame-rate enable standing in for the transmit clock.
    st_nxt.tick = st_r.div_cnt == WORD_DIV_LAST;
    st_nxt.div_cnt = st_nxt.tick ? 3'h0 : st_r.div_cnt + 3'h1;
    case (st_r.rb_state)
      RB_IDLE: begin
        if (rb_loaded && tap_rti) begin
          st_nxt.rb_state = RB_RUN;
          st_nxt.rb_cnt = 22'h000000;
        end
      end
      RB_RUN: begin
        if (st_r.tick) begin
          if (st_r.rb_cnt == RB_LAST) begin
            st_nxt.rb_state = RB_DONE;
          end else begin
            st_nxt.rb_cnt = st_r.rb_cnt + 22'h000001;
          end
        end
      end
      RB_DONE: begin
        if (!rb_loaded) begin
          st_nxt.rb_state = RB_IDLE;
        end
      end
      default: st_nxt.rb_state = RB_IDLE;
    endcase
    // Write channel.
    if (aw_hs) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (w_hs) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.aw_held && st_r.w_held) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        wmask[b*8 +: 8] = {8{st_r.w_strb[b]}};
      end
      if (st_r.aw_addr == REG_CONTROL) begin
        st_nxt.control = (st_r.control & ~wmask) | (st_r.w_data & wmask);
      end else if (st_r.aw_addr != REG_STATUS &&
        st_r.aw_addr != REG_FRAMES) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Read channel.
    status[ST_ACTIVE_LSB +: 8] = ch_active;
    status[ST_BIST_LSB +: 8] = bist_vec;
    status[ST_PLL] = ms_n;
    status[ST_RB_BUSY] = rb_run;
    status[ST_RB_DONE] = st_r.rb_state == RB_DONE;
    status[ST_RX_PASS] = rx_pass;
    status[ST_RX_DONE] = rx_done;
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (araddr)
        REG_CONTROL: st_nxt.rdata = st_r.control;
        REG_STATUS: st_nxt.rdata = status;
        REG_FRAMES: st_nxt.rdata = {10'h000, st_r.rb_cnt};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{pin_s1: '0, pin_s2: '0, div_cnt: 3'h0, tick: 1'b0,
        rb_state: RB_IDLE, rb_cnt: 22'h000000, bist_any: 1'b0,
        control: CONTROL_RST, aw_held: 1'b0, aw_addr: 8'h00,
        w_held: 1'b0, w_data: 32'h0000_0000, w_strb: 4'h0,
        bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
        rdata: 32'h0000_0000, rresp: RESP_OKAY};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  // ==========================================================
  // Checks
  property p_drive_off;
    @(posedge aclk) disable iff (!aresetn)
    !drv_en |=> serial_out_oe == 8'h00;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("Outputs driven while drive enable is low.");

  property p_master_sleep;
    @(posedge aclk) disable iff (!aresetn)
    !ms_n |-> !pll_run ##1 serial_out_oe == 8'h00;
  endproperty
  a_master_sleep: assert property (p_master_sleep)
    else $error("Master sleep did not stop PLL and float outputs.");

  property p_sel_one;
    @(posedge aclk) disable iff (!aresetn)
    act && !sel[3] && !rb_run |-> bist_vec == (8'h01 << sel[2:0]);
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("Single-channel self-test decode wrong.");

  property p_sel_all;
    @(posedge aclk) disable iff (!aresetn)
    act && sel == SEL_ALL |-> bist_vec == 8'hff;
  endproperty
  a_sel_all: assert property (p_sel_all)
    else $error("All-channel self-test not enabled.");

  property p_sel_none;
    @(posedge aclk) disable iff (!aresetn)
    act && sel > SEL_ALL && !rb_run |-> bist_vec == 8'h00;
  endproperty
  a_sel_none: assert property (p_sel_none)
    else $error("Self-test ran for a reserved select value.");

  property p_inactive;
    @(posedge aclk) disable iff (!aresetn)
    !act && !rb_run |-> bist_vec == 8'h00;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("Self-test ran while not activated.");

  property p_rb_start;
    @(posedge aclk) disable iff (!aresetn)
    st_r.rb_state == RB_IDLE && rb_loaded && tap_rti |=>
      rb_run ##1 bist_vec == 8'hff;
  endproperty
  a_rb_start: assert property (p_rb_start)
    else $error("Scan self-test did not start from idle.");

  property p_rb_end;
    @(posedge aclk) disable iff (!aresetn)
    rb_run && st_r.tick && st_r.rb_cnt == RB_LAST |=>
      st_r.rb_state == RB_DONE;
  endproperty
  a_rb_end: assert property (p_rb_end)
    else $error("Scan self-test did not end after its frame count.");

endmodule

// ==== tb/ser_remote_model.sv ====
// Remote receivers and scan controller facing the serializer.
`timescale 1ns/1ps
module ser_remote_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial side and bench commands
  input wire logic [95:0] serial_frame,
  input wire logic [7:0] serial_out_oe,
  input wire logic [7:0] cut,
  input wire logic bist_go,
  // Answers to the serializer
  output logic [7:0] link_align_request,
  output logic runbist_loaded,
  output logic tap_run_test_idle,
  output logic remote_bist_pass,
  output logic remote_bist_done
);
  logic [1:0] div = 2'h0;
  logic [7:0] miss;
  logic [11:0] last [8];
  logic [11:0] f;
  int t;

  // Each receiver looks once per frame and raises its align request after two bad frames.
  always @(posedge aclk) begin
    div <= div + 2'h1;
    if (!aresetn) begin
      miss <= 8'h00;
      link_align_request <= 8'hff;
    end else if (div == 2'h0) begin
      for (int c = 0; c < 8; c++) begin
        f = serial_frame[12*c +: 12];
        if (cut[c] || !serial_out_oe[c] || f[11] !== 1'b1 ||
          f[0] !== 1'b0) begin
          miss[c] <= 1'b1;
          if (miss[c]) link_align_request[c] <= 1'b1;
        end else begin
          miss[c] <= 1'b0;
          if (f == 12'hfc0 || f != last[c]) begin
            link_align_request[c] <= 1'b0;
          end
        end
        last[c] <= f;
      end
    end
  end

  // The scan port idles first, the receiver reports well inside 4K clocks.
  always @(posedge aclk) begin
    if (!aresetn || !bist_go) begin
      t <= 0;
      runbist_loaded <= 1'b0;
      tap_run_test_idle <= 1'b0;
      remote_bist_pass <= 1'b0;
      remote_bist_done <= 1'b0;
    end else begin
      t <= t + 1;
      runbist_loaded <= 1'b1;
      if (t == 40) tap_run_test_idle <= 1'b1;
      if (t == 200) remote_bist_pass <= 1'b1;
      if (t == 200) remote_bist_done <= 1'b1;
    end
  end
endmodule

// ==== tb/serializer_power_tristate_bist_ctrl_bench.sv ====
// Self-checking bench of the serializer control block.
`timescale 1ns/1ps
module serializer_power_tristate_bist_ctrl_bench;
  import ser_ctrl_pkg::*;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
    logic [31:0] mask;
  } note_s;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pll_run;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, ev;
  logic [3:0] wstrb = 4'hf, selftest_channel_select = 4'hf;
  logic [1:0] bresp, rresp;
  logic master_sleep_n = 1'b1, output_drive_enable = 1'b1;
  logic [7:0] channel_sleep_n = 8'hff, cut = 8'h00, extest_data = 8'h00;
  logic [7:0] link_align_request, serial_out_oe;
  logic [79:0] parallel_data_in = '0;
  logic [95:0] pd, serial_frame;
  logic selftest_activate = 1'b0, extest_active = 1'b0, bist_go = 1'b0;
  logic runbist_loaded, tap_run_test_idle, remote_bist_pass, remote_bist_done;
  int fail_count = 0, n_compared = 0, cyc = 0;
  note_s q[$];
  note_s n;

  serializer_power_tristate_bist_ctrl #(.RUNBIST_FRAMES(20)) dut (.*);
  ser_remote_model far (.*);

  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks and the response watcher
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    q.push_back('{e, 32'h0, 32'h0});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      ad = ad || awready;
      dd = dd || wready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m, input logic [1:0] e);
    @(posedge aclk);
    q.push_back('{e, v, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  always @(negedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      n = q.pop_front();
      chk({30'h0, bvalid ? bresp : rresp}, {30'h0, n.resp});
      if (rvalid) chk(rdata & n.mask, n.data);
    end
  end

  // Frame of a channel, or the enables, or the align requests.
  function automatic logic [11:0] look(input int c);
    if (c < 8) return serial_frame[12*c +: 12];
    return {4'h0, c == 8 ? serial_out_oe : link_align_request};
  endfunction

  // Pattern bits of one frame from a seed, x^7 + x^6 + 1, oldest first.
  function automatic logic [9:0] prbs_ref(input logic [6:0] s);
    logic [6:0] v;
    logic [9:0] w;
    v = s;
    w = 10'h000;
    for (int i = 0; i < 10; i++) begin
      w = {w[8:0], v[6]};
      v = {v[5:0], v[6] ^ v[5]};
    end
    return w;
  endfunction

  task automatic wt(input int c, input logic [11:0] v, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (i < lim && look(c) !== v);
    chk({20'h0, look(c)}, {20'h0, v});
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(34525));
    repeat (16) @(negedge aclk);
    chk({23'h0, pll_run, serial_out_oe}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CONTROL, CONTROL_RST, 32'hffffffff, RESP_OKAY);
    wt(8, 12'h0ff, 60);
    wt(9, 12'h000, 300);
    pd = {$urandom(), $urandom(), $urandom()};
    parallel_data_in <= pd[79:0];
    wt(2, {1'b1, pd[29:20], 1'b0}, 30);
    cut <= 8'h02;
    wt(1, SYNC_FRAME, 80);
    chk(serial_out_oe, 8'hff);
    cut <= 8'h00;
    wt(1, {1'b1, pd[19:10], 1'b0}, 120);
    output_drive_enable <= 1'b0;
    wt(8, 12'h000, 6);
    output_drive_enable <= 1'b1;
    wt(8, 12'h0ff, 6);
    chk(look(2), {1'b1, pd[29:20], 1'b0});
    wt(9, 12'h000, 300);
    channel_sleep_n <= 8'hf7;
    wt(8, 12'h0f7, 6);
    chk(pll_run, 1'b1);
    chk(look(2), {1'b1, pd[29:20], 1'b0});
    channel_sleep_n <= 8'hff;
    repeat (20) @(negedge aclk);
    chk(serial_out_oe[3], 1'b0);
    wt(8, 12'h0ff, 30);
    master_sleep_n <= 1'b0;
    wt(8, 12'h000, 6);
    chk(pll_run, 1'b0);
    master_sleep_n <= 1'b1;
    wt(8, 12'h0ff, 60);
    chk(pll_run, 1'b1);
    ev = $urandom();
    extest_data <= ev[7:0];
    extest_active <= 1'b1;
    wt(0, {12{ev[0]}}, 10);
    chk(look(7), {12{ev[7]}});
    channel_sleep_n <= 8'hfe;
    wt(8, 12'h0fe, 6);
    extest_active <= 1'b0;
    channel_sleep_n <= 8'hff;
    wt(9, 12'h000, 300);
    for (int s = 0; s < 17; s++) begin
      selftest_activate <= s < 16;
      selftest_channel_select <= s < 16 ? s[3:0] : 4'hf;
      ev = 32'h1_0000 | (s < 8 ? 32'h100 << s : (s == 8 ? 32'hff00 : 32'h0));
      repeat (6) @(posedge aclk);
      rd(REG_STATUS, ev, 32'h1_ff00, RESP_OKAY);
    end
    wr(REG_CONTROL, 32'h0000_0051, RESP_OKAY);
    wt(5, {1'b1, prbs_ref(PRBS_SEED), 1'b0}, 40);
    rd(REG_CONTROL, 32'h51, 32'hff, RESP_OKAY);
    rd(REG_STATUS, 32'h2000, 32'hff00, RESP_OKAY);
    wr(REG_CONTROL, 32'h0, RESP_OKAY);
    wr(8'h0c, 32'h1, RESP_SLVERR);
    rd(8'h0c, 32'h0, 32'hffffffff, RESP_SLVERR);
    bist_go <= 1'b1;
    repeat (60) @(posedge aclk);
    rd(REG_STATUS, 32'h2_ff00, 32'h6_ff00, RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(REG_STATUS, 32'h1c_0000, 32'h1e_0000, RESP_OKAY);
    bist_go <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(REG_STATUS, 32'h0, 32'h1e_0000, RESP_OKAY);
    end_of_test();
  end
endmodule
